// [dsc_regs.svh]
// Register offsets, field positions, reset values and sizes of the statistics collector
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH

`define DSC_CNT_W 32
`define DSC_LVL_W 8
`define DSC_ID_W 8
`define DSC_NUM_TASK 64
`define DSC_NUM_CLASS 8
`define DSC_NUM_LVL 5

`define DSC_OFF_CTRL 12'h000
`define DSC_OFF_CONFIG 12'h004
`define DSC_OFF_CYCLE 12'h008
`define DSC_OFF_CID0_TICKS 12'h00c
`define DSC_OFF_INSTR 12'h040
`define DSC_OFF_LVL 12'h080
`define DSC_OFF_TASK_RUN 12'h100
`define DSC_OFF_TASK_SENT 12'h200
`define DSC_OFF_TASK_TICKS 12'h300
`define DSC_OFF_CID_RUN 12'h400

`define DSC_CTRL_RUN_BIT 0
`define DSC_CTRL_CLR_BIT 1
`define DSC_CTRL_RST 2'h1
`define DSC_LVL_MIN_RST 8'hff

`endif

// [dsc_pkg.sv]
// Types shared by the statistics collector modules
package dsc_pkg;
  typedef enum logic [2:0] {
    DSC_CLS_LOAD = 3'h0,
    DSC_CLS_STORE = 3'h1,
    DSC_CLS_ALU = 3'h2,
    DSC_CLS_BRANCH = 3'h3,
    DSC_CLS_CALL = 3'h4,
    DSC_CLS_EXIT = 3'h5,
    DSC_CLS_SEND = 3'h6,
    DSC_CLS_OTHER = 3'h7
  } dsc_instr_class_t;

  typedef enum logic [2:0] {
    DSC_LVL_FREE_CID = 3'h0,
    DSC_LVL_IN_TASK = 3'h1,
    DSC_LVL_OUT_TASK = 3'h2,
    DSC_LVL_CID_REORDER = 3'h3,
    DSC_LVL_SEQ_REORDER = 3'h4
  } dsc_lvl_sel_t;
endpackage

// [dsc_lvl_if.sv]
// Level tracker link: present level in, present/highest/lowest out
`timescale 1ns/1ps
`include "dsc_regs.svh"
interface dsc_lvl_if;
  logic en;
  logic clr;
  logic [`DSC_LVL_W-1:0] level;
  logic [`DSC_LVL_W-1:0] cur;
  logic [`DSC_LVL_W-1:0] hi;
  logic [`DSC_LVL_W-1:0] lo;
  modport tracker (input en, input clr, input level, output cur, output hi, output lo);
  modport owner (output en, output clr, output level, input cur, input hi, input lo);
endinterface

// [dsc_level_track.sv]
// Present, highest and lowest occupancy tracker for one queue
`timescale 1ns/1ps
`include "dsc_regs.svh"
module dsc_level_track (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Level link
  dsc_lvl_if.tracker lv
);
  logic primed_r;
  logic [`DSC_LVL_W-1:0] cur_r;
  logic [`DSC_LVL_W-1:0] hi_r;
  logic [`DSC_LVL_W-1:0] lo_r;

  // Async reset cannot load a port, so the first clocked cycle seeds the extremes
  wire load = !primed_r || lv.clr;
  wire new_hi = lv.level > hi_r;
  wire new_lo = lv.level < lo_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      primed_r <= 1'b0;
      cur_r <= '0;
      hi_r <= '0;
      lo_r <= `DSC_LVL_MIN_RST;
    end
    else if (lv.en)
    begin
      primed_r <= 1'b1;
      cur_r <= lv.level;
      hi_r <= (load || new_hi) ? lv.level : hi_r;
      lo_r <= (load || new_lo) ? lv.level : lo_r;
    end
  end

  assign lv.cur = cur_r;
  assign lv.hi = hi_r;
  assign lv.lo = lo_r;
endmodule // dsc_level_track

// [dsc_top.sv]
// Debug statistics collector for the multithreaded core and message unit
//
// Overview of operation
// - Build option includes whole collector, both monitored
// - Count executed instructions in eight classes
// - Per context identifier run counts absent in dual-core; context zero cycles kept
// - Count task runs per task id, 64 ids
// - Count messages sent per first 64 tasks
// - Record last start-to-end cycles per task
// - Record last task cycles for context zero
// - Free context FIFO present, highest, lowest level
// - Input task queue present, highest, lowest level
// - Output task queue present, highest, lowest level
// - Context reorder queue present, highest, lowest level
// - Sequence reorder tracked only with ordering enforced
`timescale 1ns/1ps
`include "dsc_regs.svh"
module dsc_top #(
  parameter bit EN_STATS = 1'b1,
  parameter bit EN_INSTR = 1'b1,
  parameter bit EN_CID = 1'b1,
  parameter bit DUAL_CORE = 1'b0,
  parameter bit EN_IN_TASK = 1'b1,
  parameter bit EN_OUT_TASK = 1'b1,
  parameter bit EN_TICKS = 1'b1,
  parameter bit EN_CID0 = 1'b1,
  parameter bit EN_LVL_FREE = 1'b1,
  parameter bit EN_LVL_IN = 1'b1,
  parameter bit EN_LVL_OUT = 1'b1,
  parameter bit EN_LVL_CIDR = 1'b1,
  parameter bit EN_LVL_SEQ = 1'b1,
  parameter bit SEQ_ORDER_EN = 1'b1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Multithreaded core instruction retire
  input wire logic instr_valid,
  input wire dsc_pkg::dsc_instr_class_t instr_class,
  // Task start and completion
  input wire logic task_start,
  input wire logic [`DSC_ID_W-1:0] task_start_id,
  input wire logic [`DSC_ID_W-1:0] task_start_context_identifier,
  input wire logic task_done,
  input wire logic [`DSC_ID_W-1:0] task_done_id,
  input wire logic [`DSC_ID_W-1:0] task_done_context_identifier,
  // Processing element message sent
  input wire logic msg_sent,
  input wire logic [`DSC_ID_W-1:0] msg_sent_task_id,
  // Message unit levels
  input wire logic [`DSC_LVL_W-1:0] level_free_context_identifier,
  input wire logic [`DSC_LVL_W-1:0] level_in_task,
  input wire logic [`DSC_LVL_W-1:0] level_out_task,
  input wire logic [`DSC_LVL_W-1:0] level_context_reorder,
  input wire logic [`DSC_LVL_W-1:0] level_seq_reorder
);
  localparam int NT = `DSC_NUM_TASK;
  localparam int NL = `DSC_NUM_LVL;

  // Every group is also gated by the top-level option
  localparam bit G_INSTR = EN_STATS && EN_INSTR;
  localparam bit G_CID = EN_STATS && EN_CID && !DUAL_CORE;
  localparam bit G_IN = EN_STATS && EN_IN_TASK;
  localparam bit G_OUT = EN_STATS && EN_OUT_TASK;
  localparam bit G_TICK = EN_STATS && EN_TICKS;
  localparam bit G_CID0 = EN_STATS && EN_CID0;
  localparam bit [NL-1:0] G_LVL = {
    EN_STATS && EN_LVL_SEQ && SEQ_ORDER_EN,
    EN_STATS && EN_LVL_CIDR,
    EN_STATS && EN_LVL_OUT,
    EN_STATS && EN_LVL_IN,
    EN_STATS && EN_LVL_FREE
  };

  // Task ids above the first 64 are not counted
  function automatic logic id_ok(input logic [`DSC_ID_W-1:0] id);
    id_ok = (id < `DSC_ID_W'(NT));
  endfunction

  function automatic logic [5:0] id_idx(input logic [`DSC_ID_W-1:0] id);
    id_idx = id[5:0];
  endfunction

  // Counters wrap rather than saturate; software works with deltas
  function automatic logic [`DSC_CNT_W-1:0] bump(input logic [`DSC_CNT_W-1:0] v);
    bump = v + 1'b1;
  endfunction

  // Elapsed cycles since a stamp, right across a wrap of the time base
  function automatic logic [`DSC_CNT_W-1:0] span(input logic [`DSC_CNT_W-1:0] now_v,
    input logic [`DSC_CNT_W-1:0] start_v);
    span = now_v - start_v;
  endfunction

  // Control and free-running time base
  logic run_r;
  logic clr_r;
  logic [`DSC_CNT_W-1:0] cycle_r;

  // Counter storage
  logic [`DSC_CNT_W-1:0] instr_cnt_r [`DSC_NUM_CLASS];
  logic [`DSC_CNT_W-1:0] run_cnt_r [NT];
  logic [`DSC_CNT_W-1:0] sent_cnt_r [NT];
  logic [`DSC_CNT_W-1:0] stamp_r [NT];
  logic [`DSC_CNT_W-1:0] ticks_r [NT];
  logic [`DSC_CNT_W-1:0] cid_cnt_r [NT];
  logic [`DSC_CNT_W-1:0] cid0_stamp_r;
  logic [`DSC_CNT_W-1:0] cid0_ticks_r;

  // Bus data phase
  logic dp_wr_r;
  logic [11:0] dp_addr_r;
  logic [31:0] hrdata_r;

  // Event qualifiers
  wire live = run_r && !clr_r;
  wire ev_instr = G_INSTR && live && instr_valid;
  wire ev_run = G_IN && live && task_start && id_ok(task_start_id);
  wire ev_sent = G_OUT && live && msg_sent && id_ok(msg_sent_task_id);
  wire ev_tstart = G_TICK && live && task_start && id_ok(task_start_id);
  wire ev_tdone = G_TICK && live && task_done && id_ok(task_done_id);
  wire ev_cid = G_CID && live && task_start && id_ok(task_start_context_identifier);
  wire ev_c0start = G_CID0 && live && task_start && (task_start_context_identifier == '0);
  wire ev_c0done = G_CID0 && live && task_done && (task_done_context_identifier == '0);
  wire [5:0] run_i = id_idx(task_start_id);
  wire [5:0] done_i = id_idx(task_done_id);
  wire [5:0] sent_i = id_idx(msg_sent_task_id);
  wire [5:0] cid_i = id_idx(task_start_context_identifier);

  // Level trackers
  wire [`DSC_LVL_W-1:0] lvl_in [NL];
  logic [`DSC_LVL_W-1:0] lvl_cur [NL];
  logic [`DSC_LVL_W-1:0] lvl_hi [NL];
  logic [`DSC_LVL_W-1:0] lvl_lo [NL];
  assign lvl_in[dsc_pkg::DSC_LVL_FREE_CID] = level_free_context_identifier;
  assign lvl_in[dsc_pkg::DSC_LVL_IN_TASK] = level_in_task;
  assign lvl_in[dsc_pkg::DSC_LVL_OUT_TASK] = level_out_task;
  assign lvl_in[dsc_pkg::DSC_LVL_CID_REORDER] = level_context_reorder;
  assign lvl_in[dsc_pkg::DSC_LVL_SEQ_REORDER] = level_seq_reorder;

  // Disabled trackers keep their reset values, so they read 0, 0 and ff
  for (genvar q = 0; q < NL; q++)
  begin : g_lvl
    dsc_lvl_if lif ();
    assign lif.en = G_LVL[q];
    assign lif.clr = clr_r;
    assign lif.level = lvl_in[q];
    assign lvl_cur[q] = lif.cur;
    assign lvl_hi[q] = lif.hi;
    assign lvl_lo[q] = lif.lo;
    dsc_level_track u_trk (
      .hclk(hclk),
      .hresetn(hresetn),
      .lv(lif.tracker)
    );
  end

  // Bus address phase decode; zero wait state, always OKAY
  wire ap_take = hsel && hready && htrans[1];
  wire ap_wr = ap_take && hwrite && (hsize == 3'h2);
  wire [11:0] ap_addr = {haddr[11:2], 2'h0};
  wire [3:0] pg = ap_addr[11:8];
  wire [5:0] wi = ap_addr[7:2];
  wire rd_take = ap_take && !hwrite;
  wire dp_ctrl_wr = dp_wr_r && (dp_addr_r == `DSC_OFF_CTRL);

  // Level block: three words per queue, one queue per 16 bytes
  wire [2:0] lq = ap_addr[6:4];
  wire [1:0] lf = ap_addr[3:2];
  wire lvl_hit = (ap_addr[11:7] == `DSC_OFF_LVL >> 7) && (lq < 3'(NL)) && (lf != 2'h3);
  wire [`DSC_LVL_W-1:0] lvl_sel =
    (lf == 2'h0) ? lvl_cur[lq] : (lf == 2'h1) ? lvl_hi[lq] : lvl_lo[lq];
  wire instr_hit = (ap_addr[11:5] == `DSC_OFF_INSTR >> 5);
  wire [31:0] cfg_word = {18'h0, SEQ_ORDER_EN, DUAL_CORE, G_LVL, G_CID0, G_TICK,
    G_OUT, G_IN, G_CID, G_INSTR, EN_STATS};
  wire [31:0] ctrl_word = {30'h0, clr_r, run_r};

  wire [31:0] rd_word =
    (ap_addr == `DSC_OFF_CTRL) ? ctrl_word :
    (ap_addr == `DSC_OFF_CONFIG) ? cfg_word :
    (ap_addr == `DSC_OFF_CYCLE) ? cycle_r :
    (ap_addr == `DSC_OFF_CID0_TICKS) ? cid0_ticks_r :
    instr_hit ? instr_cnt_r[ap_addr[4:2]] :
    lvl_hit ? {24'h0, lvl_sel} :
    (pg == `DSC_OFF_TASK_RUN >> 8) ? run_cnt_r[wi] :
    (pg == `DSC_OFF_TASK_SENT >> 8) ? sent_cnt_r[wi] :
    (pg == `DSC_OFF_TASK_TICKS >> 8) ? ticks_r[wi] :
    (pg == `DSC_OFF_CID_RUN >> 8) ? cid_cnt_r[wi] :
    32'h0;

  // Every register answers at once, so the slave never stalls the bus
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= 12'h0;
      hrdata_r <= 32'h0;
    end
    else
    begin
      dp_wr_r <= ap_wr;
      dp_addr_r <= ap_addr;
      hrdata_r <= rd_take ? rd_word : hrdata_r;
    end
  end

  // Clear is a one-cycle pulse; it reseeds the level extremes too
  wire run_nxt = dp_ctrl_wr ? hwdata[`DSC_CTRL_RUN_BIT] : run_r;
  wire clr_nxt = dp_ctrl_wr && hwdata[`DSC_CTRL_CLR_BIT];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_r <= 1'(`DSC_CTRL_RST >> `DSC_CTRL_RUN_BIT);
      clr_r <= 1'(`DSC_CTRL_RST >> `DSC_CTRL_CLR_BIT);
    end
    else
    begin
      run_r <= run_nxt;
      clr_r <= clr_nxt;
    end
  end

  // Free-running time base; it wraps, so spans stay right modulo its width
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cycle_r <= '0;
    else
      cycle_r <= cycle_r + 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int c = 0; c < `DSC_NUM_CLASS; c++)
        instr_cnt_r[c] <= '0;
    end
    else if (clr_r)
    begin
      for (int c = 0; c < `DSC_NUM_CLASS; c++)
        instr_cnt_r[c] <= '0;
    end
    else if (ev_instr)
      instr_cnt_r[instr_class] <= bump(instr_cnt_r[instr_class]);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int t = 0; t < NT; t++)
      begin
        run_cnt_r[t] <= '0;
        sent_cnt_r[t] <= '0;
        cid_cnt_r[t] <= '0;
      end
    end
    else if (clr_r)
    begin
      for (int t = 0; t < NT; t++)
      begin
        run_cnt_r[t] <= '0;
        sent_cnt_r[t] <= '0;
        cid_cnt_r[t] <= '0;
      end
    end
    else
    begin
      // A clear in the same cycle wins over any event
      if (ev_run)
        run_cnt_r[run_i] <= bump(run_cnt_r[run_i]);
      if (ev_sent)
        sent_cnt_r[sent_i] <= bump(sent_cnt_r[sent_i]);
      if (ev_cid)
        cid_cnt_r[cid_i] <= bump(cid_cnt_r[cid_i]);
    end
  end

  // Start stamp per task; the duration is the difference at completion
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int t = 0; t < NT; t++)
      begin
        stamp_r[t] <= '0;
        ticks_r[t] <= '0;
      end
    end
    else if (clr_r)
    begin
      for (int t = 0; t < NT; t++)
        ticks_r[t] <= '0;
    end
    else
    begin
      if (ev_tstart)
        stamp_r[run_i] <= cycle_r;
      if (ev_tdone)
        ticks_r[done_i] <= span(cycle_r, stamp_r[done_i]);
    end
  end

  // Same-cycle start and done of the same id reports the older task
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cid0_stamp_r <= '0;
      cid0_ticks_r <= '0;
    end
    else if (clr_r)
      cid0_ticks_r <= '0;
    else
    begin
      if (ev_c0start)
        cid0_stamp_r <= cycle_r;
      if (ev_c0done)
        cid0_ticks_r <= span(cycle_r, cid0_stamp_r);
    end
  end
endmodule // dsc_top

// [dsc_checker.sv]
// Port checker for the statistics collector, bound to its top
`timescale 1ns/1ps
`include "dsc_regs.svh"
module dsc_checker (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // Watched queue level
  input wire logic [`DSC_LVL_W-1:0] level_in_task
);
  logic wr_r;
  logic clr_q;
  logic [11:0] a_r;
  logic [7:0] cur_r, hi_r, lo_r;
  wire take = hsel && hready && htrans[1];
  // Clear pulse follows the data edge; reseed from the level one edge later
  wire clr = wr_r && a_r == `DSC_OFF_CTRL && hwdata[`DSC_CTRL_CLR_BIT];
  wire [7:0] hi_nxt = (clr_q || level_in_task > hi_r) ? level_in_task : hi_r;
  wire [7:0] lo_nxt = (clr_q || level_in_task < lo_r) ? level_in_task : lo_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_r <= 1'b0;
      clr_q <= 1'b0;
      a_r <= 12'h000;
      cur_r <= 8'h00;
      hi_r <= 8'h00;
      lo_r <= 8'hff;
    end
    else
    begin
      wr_r <= take && hwrite && hsize == 3'h2;
      clr_q <= clr;
      a_r <= {haddr[11:2], 2'h0};
      cur_r <= level_in_task;
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd(logic [11:0] a);
    take && !hwrite && haddr[11:0] == a;
  endsequence
  property p_ready; hreadyout == 1'b1; endproperty
  property p_okay; hresp == 1'b0; endproperty
  property p_stand; !(take && !hwrite) |=> $stable(hrdata); endproperty
  property p_cfg; s_rd(`DSC_OFF_CONFIG) |=> hrdata == 32'h00002fff; endproperty
  property p_unmap; s_rd(12'h010) |=> hrdata == 32'h00000000; endproperty
  property p_cur; s_rd(12'h090) |=> hrdata == {24'h0, $past(cur_r)}; endproperty
  property p_hi; s_rd(12'h094) |=> hrdata == {24'h0, $past(hi_r)}; endproperty
  property p_lo; s_rd(12'h098) |=> hrdata == {24'h0, $past(lo_r)}; endproperty
  a_ready: assert property (p_ready) else $error("ready dropped");
  a_okay: assert property (p_okay) else $error("error response");
  a_stand: assert property (p_stand) else $error("read data moved");
  a_cfg: assert property (p_cfg) else $error("build options wrong");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_cur: assert property (p_cur) else $error("present level wrong");
  a_hi: assert property (p_hi) else $error("highest level wrong");
  a_lo: assert property (p_lo) else $error("lowest level wrong");
endmodule // dsc_checker
bind dsc_top dsc_checker u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .level_in_task(level_in_task)
);

// [dsc_partner.sv]
// Model of the core and message unit feeding collector events
`timescale 1ns/1ps
module dsc_partner (
  // Clock
  input wire logic hclk,
  // Events
  output logic instr_valid,
  output dsc_pkg::dsc_instr_class_t instr_class,
  output logic task_start,
  output logic [7:0] start_id,
  output logic [7:0] start_cx,
  output logic task_done,
  output logic [7:0] done_id,
  output logic [7:0] done_cx,
  output logic msg_sent,
  output logic [7:0] sent_id,
  // Queue levels
  output logic [7:0] lv [5]
);
  initial
  begin
    {instr_valid, task_start, task_done, msg_sent} = 4'h0;
    instr_class = dsc_pkg::DSC_CLS_OTHER;
    {start_id, start_cx, done_id, done_cx, sent_id} = {5{8'h55}};
    lv = '{5{8'h03}};
  end
  // Ids and class flip after each pulse, qualifiers drop, so stale ids never look valid
  task automatic instr(input dsc_pkg::dsc_instr_class_t c, input int n);
    @(posedge hclk);
    instr_valid <= 1'b1;
    instr_class <= c;
    repeat (n) @(posedge hclk);
    instr_valid <= 1'b0;
    instr_class <= dsc_pkg::dsc_instr_class_t'(~c);
  endtask
  task automatic start(input logic [7:0] id, input logic [7:0] cx);
    @(posedge hclk);
    task_start <= 1'b1;
    start_id <= id;
    start_cx <= cx;
    @(posedge hclk);
    task_start <= 1'b0;
    start_id <= ~id;
    start_cx <= ~cx;
  endtask
  task automatic done(input logic [7:0] id, input logic [7:0] cx);
    @(posedge hclk);
    task_done <= 1'b1;
    done_id <= id;
    done_cx <= cx;
    @(posedge hclk);
    task_done <= 1'b0;
    done_id <= ~id;
    done_cx <= ~cx;
  endtask
  task automatic sent(input logic [7:0] id, input int n);
    @(posedge hclk);
    msg_sent <= 1'b1;
    sent_id <= id;
    repeat (n) @(posedge hclk);
    msg_sent <= 1'b0;
    sent_id <= ~id;
  endtask
  task automatic setlv(input int q, input logic [7:0] v);
    @(posedge hclk);
    lv[q] <= v;
  endtask
endmodule // dsc_partner

// [test_debug_statistics_collector.sv]
// Self-checking bench for the statistics collector
`timescale 1ns/1ps
`include "dsc_regs.svh"
module test_debug_statistics_collector;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, iv, ts, td, ms;
  logic [31:0] hrdata;
  dsc_pkg::dsc_instr_class_t ic;
  logic [7:0] tsi, tsc, tdi, tdc, msi;
  logic [7:0] lv [5];
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  always #5 hclk = ~hclk;
  dsc_partner p (.hclk(hclk), .instr_valid(iv), .instr_class(ic), .task_start(ts),
    .start_id(tsi), .start_cx(tsc), .task_done(td), .done_id(tdi), .done_cx(tdc),
    .msg_sent(ms), .sent_id(msi), .lv(lv));
  dsc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .instr_valid(iv),
    .instr_class(ic), .task_start(ts), .task_start_id(tsi),
    .task_start_context_identifier(tsc), .task_done(td), .task_done_id(tdi),
    .task_done_context_identifier(tdc), .msg_sent(ms), .msg_sent_task_id(msi),
    .level_free_context_identifier(lv[0]), .level_in_task(lv[1]),
    .level_out_task(lv[2]), .level_context_reorder(lv[3]), .level_seq_reorder(lv[4]));
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(hrdata, exp);
  endtask
  task automatic t_config;
    logic [31:0] first;
    rd(`DSC_OFF_CONFIG, 32'h00002fff);
    rd(12'h010, 32'h0);
    xfer(1'b0, `DSC_OFF_CYCLE, 32'h0);
    first = hrdata;
    xfer(1'b0, `DSC_OFF_CYCLE, 32'h0);
    chk(hrdata - first, 32'h3);
  endtask
  task automatic t_instr;
    for (int c = 0; c < 8; c++)
      p.instr(dsc_pkg::dsc_instr_class_t'(c), c + 1);
    for (int c = 0; c < 8; c++)
      rd(`DSC_OFF_INSTR + 12'(4 * c), 32'(c + 1));
  endtask
  task automatic t_task;
    p.start(8'h3f, 8'h00);
    @(posedge hclk);
    p.done(8'h3f, 8'h00);
    p.start(8'h3f, 8'h01);
    repeat (5) @(posedge hclk);
    p.done(8'h3f, 8'h01);
    rd(`DSC_OFF_TASK_RUN + 12'h0fc, 32'h2);
    rd(`DSC_OFF_TASK_TICKS + 12'h0fc, 32'h7);
    rd(`DSC_OFF_CID0_TICKS, 32'h3);
    rd(`DSC_OFF_CID_RUN, 32'h1);
    rd(`DSC_OFF_CID_RUN + 12'h004, 32'h1);
  endtask
  task automatic t_sent;
    p.sent(8'h00, 2);
    p.sent(8'h3f, 1);
    p.sent(8'h40, 3);
    rd(`DSC_OFF_TASK_SENT, 32'h2);
    rd(`DSC_OFF_TASK_SENT + 12'h0fc, 32'h1);
    rd(`DSC_OFF_TASK_TICKS, 32'h0);
  endtask
  task automatic t_level;
    for (int q = 0; q < 5; q++)
    begin
      p.setlv(q, 8'h09);
      p.setlv(q, 8'h02);
      p.setlv(q, 8'h06);
      rd(`DSC_OFF_LVL + 12'(16 * q), 32'h6);
      rd(`DSC_OFF_LVL + 12'(16 * q + 4), 32'h9);
      rd(`DSC_OFF_LVL + 12'(16 * q + 8), 32'h2);
    end
  endtask
  task automatic t_clear;
    xfer(1'b1, `DSC_OFF_CTRL, 32'h3);
    rd(`DSC_OFF_INSTR, 32'h0);
    rd(`DSC_OFF_LVL + 12'h014, 32'h6);
    rd(`DSC_OFF_LVL + 12'h018, 32'h6);
    xfer(1'b1, `DSC_OFF_CTRL, 32'h0);
    p.instr(dsc_pkg::DSC_CLS_LOAD, 3);
    xfer(1'b1, `DSC_OFF_CTRL, 32'h1);
    rd(`DSC_OFF_INSTR, 32'h0);
  endtask
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      mismatches++;
      end_sim();
    end
  end
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_config();
    t_instr();
    t_task();
    t_sent();
    t_level();
    t_clear();
    end_sim();
  end
endmodule // test_debug_statistics_collector
